// ---- pkg/vtpg_pkg.sv ----
// package: register map, fields, resets and enums of the video timing and pattern generator
// Function
// - hsync starts after 24-bit trigger delay
// - hsync high for 16-bit count
// - hsync low between pulses for count
// - exact hsync pulse count per frame
// - dataen starts after 24-bit trigger delay
// - dataen high for 16-bit count
// - dataen low between pulses for count
// - exact dataen pulse count per frame
// - pattern clock from reference, four rates
// - pattern runs without link lock
// - timing from input or generated syncs
// - rgb888 patterns only in pixel mode
// - select: pass, checker, gradient, reserved
// - direction bit picks ramp up or down
// - colour step is increment over four
// - colour a from red, green, blue bytes
// - colour b from red, green, blue bytes
// - first line starts with colour a run
// - colour b follows for its run
// - after n lines lines start with b
// - enable bits pick generated or input sync
// - all timing counted in pixel clocks
// - two-bit trigger mode, free-run at reset
package vtpg_pkg;
  // register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CLKSRC = 8'h01;
  localparam logic [7:0] REG_STATUS = 8'h02;
  localparam logic [7:0] REG_HS_DLY2 = 8'h0b;
  localparam logic [7:0] REG_HS_DLY1 = 8'h0c;
  localparam logic [7:0] REG_HS_DLY0 = 8'h0d;
  localparam logic [7:0] REG_HS_HI1 = 8'h0e;
  localparam logic [7:0] REG_HS_HI0 = 8'h0f;
  localparam logic [7:0] REG_HS_LO1 = 8'h10;
  localparam logic [7:0] REG_HS_LO0 = 8'h11;
  localparam logic [7:0] REG_HS_CNT1 = 8'h12;
  localparam logic [7:0] REG_HS_CNT0 = 8'h13;
  localparam logic [7:0] REG_DE_DLY2 = 8'h14;
  localparam logic [7:0] REG_DE_DLY1 = 8'h15;
  localparam logic [7:0] REG_DE_DLY0 = 8'h16;
  localparam logic [7:0] REG_DE_HI1 = 8'h17;
  localparam logic [7:0] REG_DE_HI0 = 8'h18;
  localparam logic [7:0] REG_DE_LO1 = 8'h19;
  localparam logic [7:0] REG_DE_LO0 = 8'h1a;
  localparam logic [7:0] REG_DE_CNT1 = 8'h1b;
  localparam logic [7:0] REG_DE_CNT0 = 8'h1c;
  localparam logic [7:0] REG_PAT_MODE = 8'h1d;
  localparam logic [7:0] REG_GRADIENT_STEP_X4 = 8'h1e;
  localparam logic [7:0] REG_A_RED = 8'h1f;
  localparam logic [7:0] REG_A_GRN = 8'h20;
  localparam logic [7:0] REG_A_BLU = 8'h21;
  localparam logic [7:0] REG_B_RED = 8'h22;
  localparam logic [7:0] REG_B_GRN = 8'h23;
  localparam logic [7:0] REG_B_BLU = 8'h24;
  localparam logic [7:0] REG_A_RUN = 8'h25;
  localparam logic [7:0] REG_B_RUN = 8'h26;
  localparam logic [7:0] REG_CHK_ALT = 8'h27;
  // field positions
  localparam int CTRL_HSYNC_GENERATE_ENABLE = 0;
  localparam int CTRL_DATAEN_GENERATE_ENABLE = 1;
  localparam int CTRL_MODE_LSB = 2;
  localparam int CTRL_TUNNEL = 4;
  localparam int PAT_SEL_LSB = 0;
  localparam int PAT_DIR_BIT = 2;
  localparam int STS_HS_BUSY = 0;
  localparam int STS_DE_BUSY = 1;
  localparam int STS_PAT_ON = 2;
  localparam int STS_HS = 3;
  localparam int STS_DE = 4;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h0c;
  localparam logic [2:0] CLKSRC_RST = 3'h0;
  localparam logic [7:0] GRADIENT_STEP_X4_RST = 8'h04;
  localparam logic [7:0] CFG_RST = 8'h00;
  // trigger modes
  typedef enum logic [1:0] {
    TRIG_TRACK = 2'b00,
    TRIG_ONE = 2'b01,
    TRIG_AUTO = 2'b10,
    TRIG_FREE = 2'b11
  } vtpg_trig_e;
  // pattern select codes
  typedef enum logic [1:0] {
    PAT_PASS = 2'b00,
    PAT_CHECKER = 2'b01,
    PAT_GRADIENT = 2'b10,
    PAT_RSVD = 2'b11
  } vtpg_pat_e;
  // pulse train states
  typedef enum logic [1:0] {
    PG_IDLE = 2'b00,
    PG_DELAY = 2'b01,
    PG_HIGH = 2'b10,
    PG_LOW = 2'b11
  } vtpg_pg_e;
endpackage

// ---- src/vtpg_pulse_gen.sv ----
// file: one delayed, counted pulse train in pixel clocks
`timescale 1ns/1ps
module vtpg_pulse_gen
  import vtpg_pkg::*;
#(
  parameter int DLY_W = 24,
  parameter int LEN_W = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // frame trigger and timing
  input wire logic i_start,
  input wire logic [DLY_W-1:0] i_delay,
  input wire logic [LEN_W-1:0] i_high,
  input wire logic [LEN_W-1:0] i_low,
  input wire logic [LEN_W-1:0] i_count,
  // pulse out
  output logic o_pulse,
  output logic o_busy
);
  vtpg_pg_e st_r; // train state
  logic [DLY_W-1:0] cnt_r; // cycles spent in the current phase
  logic [LEN_W-1:0] n_r; // pulses done in this frame
  logic [LEN_W-1:0] n_nxt; // pulses done after this one
  logic [DLY_W-1:0] hi_x; // widened high count
  logic [DLY_W-1:0] lo_x; // widened low count

  assign n_nxt = n_r + 1'b1;
  assign hi_x = DLY_W'(i_high);
  assign lo_x = DLY_W'(i_low);
  assign o_pulse = (st_r == PG_HIGH);
  assign o_busy = (st_r != PG_IDLE);

  // train sequencer; a start in any state cuts or extends the old frame
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      st_r <= PG_IDLE;
      cnt_r <= '0;
      n_r <= '0;
    end else if (i_start) begin
      n_r <= '0;
      cnt_r <= DLY_W'(1);
      if (i_count == '0) begin
        st_r <= PG_IDLE;
      end else if (i_delay == '0) begin
        st_r <= PG_HIGH;
      end else begin
        st_r <= PG_DELAY;
      end
    end else begin
      unique case (st_r)
        PG_IDLE: begin
          cnt_r <= cnt_r;
        end
        PG_DELAY: begin
          if (cnt_r >= i_delay) begin
            st_r <= PG_HIGH;
            cnt_r <= DLY_W'(1);
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        PG_HIGH: begin
          if (cnt_r >= hi_x) begin
            cnt_r <= DLY_W'(1);
            n_r <= n_nxt;
            st_r <= (n_nxt >= i_count) ? PG_IDLE : PG_LOW;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        PG_LOW: begin
          if (cnt_r >= lo_x) begin
            st_r <= PG_HIGH;
            cnt_r <= DLY_W'(1);
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
      endcase
    end
  end
endmodule

// ---- src/vtpg_top.sv ----
// file: sync timing generator and test pattern generator with byte registers
//
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module vtpg_top
  import vtpg_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // input video
  input wire logic i_vs,
  input wire logic i_hs,
  input wire logic i_de,
  input wire logic [23:0] i_rgb,
  // output video to transmit pipe
  output logic o_vs,
  output logic o_hs,
  output logic o_de,
  output logic [23:0] o_rgb,
  // pixel clock source select to the clock mux
  output logic [2:0] o_pclk_src
);
  // configuration bytes, one per offset
  logic [7:0] cfg_r [REG_HS_DLY2:REG_CHK_ALT];
  logic [7:0] ctrl_r; // generate enables, trigger mode, tunnel
  logic [2:0] clksrc_r; // pixel clock source
  logic [7:0] rdata_r; // read answer
  logic [7:0] status; // live state
  logic cfg_hit; // address in the byte array

  // assembled timing values
  logic [23:0] hs_dly;
  logic [15:0] hs_hi;
  logic [15:0] hs_lo;
  logic [15:0] hsync_pulses_per_frame;
  logic [23:0] de_dly;
  logic [15:0] de_hi;
  logic [15:0] de_lo;
  logic [15:0] dataen_pulses_per_frame;
  logic hsync_generate_enable; // generated hsync in use
  logic dataen_generate_enable; // generated dataen in use
  vtpg_trig_e mode; // trigger mode
  vtpg_pat_e pat_sel; // pattern select
  logic grad_dir; // ramp down when set
  logic tunnel; // tunnel mode: no patterns

  // trigger and generator state
  logic vs_d_r; // vs one cycle ago
  logic vs_edge; // rising vs trigger
  logic frame_start; // start of a generated frame
  logic hs_pulse; // generated hsync
  logic de_pulse; // generated dataen
  logic hs_busy;
  logic de_busy;
  logic hs_cur; // selected hsync
  logic de_cur; // selected dataen
  logic de_prev_r;
  logic de_rise;
  logic de_fall;

  // pattern state
  logic pat_on; // pattern replaces input video
  logic [9:0] acc_r; // gradient value, two fraction bits
  logic [9:0] acc_use;
  logic [10:0] acc_sum;
  logic [7:0] gval; // gradient colour
  logic [7:0] run_r; // pixels done in current run
  logic [7:0] run_use;
  logic [8:0] run_next;
  logic [7:0] run_len;
  logic in_b_r; // current run is colour b
  logic use_b;
  logic phase_r; // lines start with colour b
  logic [7:0] line_r; // lines in current phase
  logic [8:0] line_next;
  logic [23:0] col_a;
  logic [23:0] col_b;
  logic [23:0] pix_nxt;

  // field decode
  assign hs_dly = {cfg_r[REG_HS_DLY2], cfg_r[REG_HS_DLY1], cfg_r[REG_HS_DLY0]};
  assign hs_hi = {cfg_r[REG_HS_HI1], cfg_r[REG_HS_HI0]};
  assign hs_lo = {cfg_r[REG_HS_LO1], cfg_r[REG_HS_LO0]};
  assign hsync_pulses_per_frame = {cfg_r[REG_HS_CNT1], cfg_r[REG_HS_CNT0]};
  assign de_dly = {cfg_r[REG_DE_DLY2], cfg_r[REG_DE_DLY1], cfg_r[REG_DE_DLY0]};
  assign de_hi = {cfg_r[REG_DE_HI1], cfg_r[REG_DE_HI0]};
  assign de_lo = {cfg_r[REG_DE_LO1], cfg_r[REG_DE_LO0]};
  assign dataen_pulses_per_frame = {cfg_r[REG_DE_CNT1], cfg_r[REG_DE_CNT0]};
  assign hsync_generate_enable = ctrl_r[CTRL_HSYNC_GENERATE_ENABLE];
  assign dataen_generate_enable = ctrl_r[CTRL_DATAEN_GENERATE_ENABLE];
  assign mode = vtpg_trig_e'(ctrl_r[CTRL_MODE_LSB +: 2]);
  assign tunnel = ctrl_r[CTRL_TUNNEL];
  assign pat_sel = vtpg_pat_e'(cfg_r[REG_PAT_MODE][PAT_SEL_LSB +: 2]);
  assign grad_dir = cfg_r[REG_PAT_MODE][PAT_DIR_BIT];
  assign col_a = {cfg_r[REG_A_RED], cfg_r[REG_A_GRN], cfg_r[REG_A_BLU]};
  assign col_b = {cfg_r[REG_B_RED], cfg_r[REG_B_GRN], cfg_r[REG_B_BLU]};
  assign cfg_hit = (i_addr >= REG_HS_DLY2) && (i_addr <= REG_CHK_ALT);

  // byte array writes; the increment resets to a step of one
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      for (int i = REG_HS_DLY2; i <= REG_CHK_ALT; i++) begin
        cfg_r[i] <= (i == REG_GRADIENT_STEP_X4) ? GRADIENT_STEP_X4_RST : CFG_RST;
      end
    end else if (i_wr && cfg_hit) begin
      cfg_r[i_addr] <= i_wdata;
    end
  end

  // control and clock source writes
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      ctrl_r <= CTRL_RST;
      clksrc_r <= CLKSRC_RST;
    end else if (i_wr) begin
      if (i_addr == REG_CTRL) begin
        ctrl_r <= {3'h0, i_wdata[4:0]};
      end
      if (i_addr == REG_CLKSRC) begin
        clksrc_r <= i_wdata[2:0];
      end
    end
  end

  assign o_pclk_src = clksrc_r;

  // live status for software
  assign status = {3'h0, de_cur, hs_cur, pat_on, de_busy, hs_busy};

  // read answer stands one cycle only; unmapped reads give zero
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      rdata_r <= 8'h00;
    end else if (!i_rd) begin
      rdata_r <= 8'h00;
    end else if (cfg_hit) begin
      rdata_r <= cfg_r[i_addr];
    end else if (i_addr == REG_CTRL) begin
      rdata_r <= ctrl_r;
    end else if (i_addr == REG_CLKSRC) begin
      rdata_r <= {5'h00, clksrc_r};
    end else if (i_addr == REG_STATUS) begin
      rdata_r <= status;
    end else begin
      rdata_r <= 8'h00;
    end
  end
  assign o_rdata = rdata_r;

  // input vs edge history
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      vs_d_r <= 1'b0;
    end else begin
      vs_d_r <= i_vs;
    end
  end
  assign vs_edge = i_vs & ~vs_d_r;

  // frame trigger per mode
  // tracking restarts on each edge; glitch filtering is not done here
  always_comb begin
    frame_start = 1'b0;
    unique case (mode)
      TRIG_TRACK: frame_start = vs_edge;
      TRIG_ONE: frame_start = vs_edge & ~hs_busy & ~de_busy;
      TRIG_AUTO: frame_start = vs_edge;
      TRIG_FREE: frame_start = ~hs_busy & ~de_busy;
    endcase
  end

  vtpg_pulse_gen #(.DLY_W(24), .LEN_W(16)) u_hs_gen (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_start(frame_start),
    .i_delay(hs_dly),
    .i_high(hs_hi),
    .i_low(hs_lo),
    .i_count(hsync_pulses_per_frame),
    .o_pulse(hs_pulse),
    .o_busy(hs_busy)
  );

  vtpg_pulse_gen #(.DLY_W(24), .LEN_W(16)) u_de_gen (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_start(frame_start),
    .i_delay(de_dly),
    .i_high(de_hi),
    .i_low(de_lo),
    .i_count(dataen_pulses_per_frame),
    .o_pulse(de_pulse),
    .o_busy(de_busy)
  );

  assign hs_cur = hsync_generate_enable ? hs_pulse : i_hs;
  assign de_cur = dataen_generate_enable ? de_pulse : i_de;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      de_prev_r <= 1'b0;
    end else begin
      de_prev_r <= de_cur;
    end
  end
  assign de_rise = de_cur & ~de_prev_r;
  assign de_fall = ~de_cur & de_prev_r;

  // pixel mode only; no link lock term
  assign pat_on = ~tunnel & ((pat_sel == PAT_CHECKER) | (pat_sel == PAT_GRADIENT));

  assign acc_use = de_rise ? 10'h000 : acc_r;
  assign acc_sum = {1'b0, acc_use} + {3'h0, cfg_r[REG_GRADIENT_STEP_X4]};
  // ramp down is the mirror of up
  assign gval = grad_dir ? ~acc_use[9:2] : acc_use[9:2];

  // gradient accumulator, wraps to start past the end value
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      acc_r <= 10'h000;
    end else if (de_cur) begin
      acc_r <= acc_sum[10] ? 10'h000 : acc_sum[9:0];
    end
  end

  // checker run bookkeeping
  assign use_b = de_rise ? phase_r : in_b_r;
  assign run_use = de_rise ? 8'h00 : run_r;
  assign run_len = use_b ? cfg_r[REG_B_RUN] : cfg_r[REG_A_RUN];
  assign run_next = {1'b0, run_use} + 9'h001;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      run_r <= 8'h00;
      in_b_r <= 1'b0;
    end else if (de_cur) begin
      if (run_next >= {1'b0, run_len}) begin
        run_r <= 8'h00;
        in_b_r <= ~use_b;
      end else begin
        run_r <= run_next[7:0];
        in_b_r <= use_b;
      end
    end
  end

  // line counter and phase; a new frame starts on colour a
  assign line_next = {1'b0, line_r} + 9'h001;
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      line_r <= 8'h00;
      phase_r <= 1'b0;
    end else if (frame_start || vs_edge) begin
      line_r <= 8'h00;
      phase_r <= 1'b0;
    end else if (de_fall) begin
      if (line_next >= {1'b0, cfg_r[REG_CHK_ALT]}) begin
        line_r <= 8'h00;
        phase_r <= ~phase_r;
      end else begin
        line_r <= line_next[7:0];
      end
    end
  end

  always_comb begin
    pix_nxt = i_rgb;
    if (pat_on && pat_sel == PAT_CHECKER) begin
      pix_nxt = use_b ? col_b : col_a;
    end else if (pat_on && pat_sel == PAT_GRADIENT) begin
      pix_nxt = {gval, gval, gval};
    end
  end

  // output stage: one register on every signal keeps them aligned
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_vs <= 1'b0;
      o_hs <= 1'b0;
      o_de <= 1'b0;
      o_rgb <= 24'h000000;
    end else begin
      o_vs <= i_vs;
      o_hs <= hs_cur;
      o_de <= de_cur;
      o_rgb <= pix_nxt;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  AST_HS_BYPASS: assert property (!hsync_generate_enable |=> o_hs == $past(i_hs))
    else $error("hsync bypass wrong");
  AST_DE_BYPASS: assert property (!dataen_generate_enable |=> o_de == $past(i_de))
    else $error("dataen bypass wrong");
  AST_HS_DELAY: assert property (frame_start && hs_dly == 24'h000003 && hsync_pulses_per_frame != 16'h0000
    |=> !hs_pulse[*3] ##1 hs_pulse)
    else $error("hsync delay wrong");
  AST_HSYNC_HIGH_TIME: assert property ($rose(hs_pulse) && hs_hi == 16'h0002
    && (mode == TRIG_ONE || mode == TRIG_FREE) |-> hs_pulse ##1 hs_pulse ##1 !hs_pulse)
    else $error("hsync width wrong");
  AST_HSYNC_LOW_TIME: assert property ($fell(hs_pulse) && hs_busy && hs_lo == 16'h0002
    && (mode == TRIG_ONE || mode == TRIG_FREE) |-> !hs_pulse ##1 !hs_pulse ##1 hs_pulse)
    else $error("hsync low time wrong");
  AST_DE_DELAY: assert property (frame_start && de_dly == 24'h000000 && dataen_pulses_per_frame != 16'h0000
    |=> de_pulse)
    else $error("dataen delay wrong");
  AST_DATAEN_HIGH_TIME: assert property ($rose(de_pulse) && de_hi == 16'h0001
    && (mode == TRIG_ONE || mode == TRIG_FREE) |=> !de_pulse)
    else $error("dataen width wrong");
  AST_DE_ONE: assert property (frame_start && dataen_pulses_per_frame == 16'h0001 && de_hi == 16'h0001
    && de_dly == 24'h000000 && mode == TRIG_ONE |=> de_pulse ##1 !de_busy)
    else $error("dataen count wrong");
  AST_TUNNEL: assert property (tunnel |=> o_rgb == $past(i_rgb))
    else $error("pattern in tunnel mode");
  AST_PASS: assert property (pat_sel == PAT_PASS |=> o_rgb == $past(i_rgb))
    else $error("pass-through broken");
  AST_GRAD_START: assert property (pat_on && pat_sel == PAT_GRADIENT && de_rise
    |=> o_rgb == ($past(grad_dir) ? 24'hffffff : 24'h000000))
    else $error("gradient start wrong");
  AST_CHK_FIRST: assert property (pat_on && pat_sel == PAT_CHECKER && de_rise && !phase_r
    |=> o_rgb == $past(col_a))
    else $error("checker first colour wrong");

  COV_CHECKER: cover property (pat_on && pat_sel == PAT_CHECKER && de_rise && phase_r);
  COV_GRADIENT: cover property (pat_on && pat_sel == PAT_GRADIENT && acc_sum[10] && de_cur);
  COV_RESTART: cover property (mode == TRIG_AUTO && vs_edge && hs_busy);
endmodule

// ---- verification/vtpg_pipe_sink.sv ----
// transmit pipe model: measures the sync trains and captures the pixels of a frame
`timescale 1ns/1ps
module vtpg_pulse_meter (
  // clock and clear
  input wire logic i_clk,
  input wire logic i_clear,
  // watched sync line
  input wire logic i_sig,
  // measurements, in pixel clocks
  output int o_pulses,
  output int o_highs,
  output int o_first,
  output int o_last
);
  int cyc = 0; // free running cycle number
  logic prev = 1'b0; // last sample, for edge detection
  // edges and high time; clear is only given while the line is idle
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    prev <= i_clear ? 1'b0 : i_sig;
    if (i_clear) begin
      o_pulses <= 0;
      o_highs <= 0;
      o_first <= 0;
      o_last <= 0;
    end else begin
      if (i_sig === 1'b1) o_highs <= o_highs + 1;
      if (i_sig === 1'b1 && prev === 1'b0) o_pulses <= o_pulses + 1;
      if (i_sig === 1'b1 && prev === 1'b0 && o_pulses == 0) o_first <= cyc;
      if (i_sig === 1'b0 && prev === 1'b1) o_last <= cyc;
    end
  end
endmodule

module vtpg_pipe_sink (
  // clock and clear
  input wire logic i_clk,
  input wire logic i_clear,
  // video from the block
  input wire logic i_hs,
  input wire logic i_de,
  input wire logic [23:0] i_rgb
);
  logic [23:0] pix_q[$]; // pixels taken while data enable is high
  int hs_pulses, hs_highs, hs_first, hs_last; // hsync measurements
  int de_pulses, de_highs, de_first, de_last; // data enable measurements
  // the pipe has no back pressure, so it takes every enabled pixel
  vtpg_pulse_meter i_vtpg_pulse_meter_hs (.i_clk(i_clk), .i_clear(i_clear), .i_sig(i_hs),
    .o_pulses(hs_pulses), .o_highs(hs_highs), .o_first(hs_first), .o_last(hs_last));
  vtpg_pulse_meter i_vtpg_pulse_meter_de (.i_clk(i_clk), .i_clear(i_clear), .i_sig(i_de),
    .o_pulses(de_pulses), .o_highs(de_highs), .o_first(de_first), .o_last(de_last));
  // pixel capture
  always @(posedge i_clk) begin
    if (i_clear) pix_q.delete();
    else if (i_de === 1'b1) pix_q.push_back(i_rgb);
  end
endmodule

// ---- verification/test_vtpg_top.sv ----
// testbench: register access, generated timing and test patterns of the generator
`timescale 1ns/1ps
module test_vtpg_top;
  import vtpg_pkg::*;
  logic i_clk = 1'b0; // pixel clock
  logic i_reset_n = 1'b0; // reset, low active
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00; // register port
  logic i_wr = 1'b0, i_rd = 1'b0; // strobes
  logic i_vs = 1'b0, i_hs = 1'b0, i_de = 1'b0; // input syncs
  logic [23:0] i_rgb = 24'h000000; // input pixel
  logic [7:0] o_rdata; // read data
  logic o_vs, o_hs, o_de; // output syncs
  logic [23:0] o_rgb; // output pixel
  logic [2:0] o_pclk_src; // clock source select
  logic clr = 1'b0; // clears the sink between frames
  int failures = 0, n_compared = 0;
  vtpg_top i_vtpg_top (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_vs(i_vs), .i_hs(i_hs), .i_de(i_de),
    .i_rgb(i_rgb), .o_vs(o_vs), .o_hs(o_hs), .o_de(o_de), .o_rgb(o_rgb), .o_pclk_src(o_pclk_src));
  vtpg_pipe_sink i_vtpg_pipe_sink (.i_clk(i_clk), .i_clear(clr), .i_hs(o_hs), .i_de(o_de), .i_rgb(o_rgb));
  // 100 MHz clock
  always #5 i_clk = ~i_clk;
  // verdict and end of run
  task automatic wrap_up;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // value comparison
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one cycle write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // one cycle read, data taken in the following cycle only
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic chk_rd(input string nm, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(nm, {24'h0, exp}, {24'h0, d});
  endtask
  // one pulse train: most significant byte at the lowest offset
  task automatic set_train(input logic [7:0] base, input logic [23:0] d, input logic [15:0] h, l, n);
    logic [71:0] v;
    v = {d, h, l, n};
    for (int i = 0; i < 9; i++) wr(base + 8'(i), v[71-8*i -: 8]);
  endtask
  // trigger one frame and wait, bounded, until both trains are idle again
  task automatic run_frame(input int n);
    logic [7:0] s;
    int k;
    clr <= 1'b1;
    @(posedge i_clk);
    clr <= 1'b0;
    i_vs <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_vs <= 1'b0;
    chk("vs_pass", 32'h1, {31'h0, o_vs});
    for (k = 0; k < 3000 && i_vtpg_pipe_sink.de_pulses < n; k++) @(posedge i_clk);
    s = 8'hff;
    for (int j = 0; j < 200 && s[1:0] != 2'b00; j++) rd(REG_STATUS, s);
    // the last falling edges leave the output registers later than the trains go idle
    repeat (3) @(posedge i_clk);
    if (k == 3000 || s[1:0] != 2'b00) begin
      failures++;
      wrap_up();
    end
  endtask
  logic [7:0] v; // expected gradient level
  logic [7:0] inc; // gradient increment
  logic dir; // gradient direction
  initial begin
    repeat (20) @(posedge i_clk);
    i_reset_n <= 1'b1;
    // reset values, write back, unmapped address
    chk_rd("ctrl", REG_CTRL, CTRL_RST);
    chk_rd("pat_mode", REG_PAT_MODE, 8'h00);
    chk_rd("gradient_step_x4", REG_GRADIENT_STEP_X4, 8'h04);
    chk_rd("clksrc", REG_CLKSRC, 8'h00);
    wr(REG_B_BLU, 8'h5a);
    chk_rd("b_blue", REG_B_BLU, 8'h5a);
    wr(8'hff, 8'h77);
    chk_rd("unmapped", 8'hff, 8'h00);
    // pixel clock source: external and all four reference rates
    for (int r = 3; r < 8; r++) begin
      wr(REG_CLKSRC, 8'(r));
      repeat (2) @(posedge i_clk);
      chk("pclk_src", 32'(r), {29'h0, o_pclk_src});
    end
    // pass through for select 00, reserved 11 and tunnel mode
    i_rgb <= 24'h123456;
    i_de <= 1'b1;
    i_hs <= 1'b1;
    for (int c = 0; c < 3; c++) begin
      wr(REG_PAT_MODE, c == 1 ? 8'h03 : 8'h00 + 8'(c == 2));
      wr(REG_CTRL, c == 2 ? 8'h14 : 8'h04);
      repeat (3) @(posedge i_clk);
      chk("pass_rgb", 32'h123456, {8'h0, o_rgb});
      chk("pass_hs_de", 32'h3, {30'h0, o_hs, o_de});
    end
    i_de <= 1'b0;
    i_hs <= 1'b0;
    wr(REG_PAT_MODE, 8'h00);
    // generated hsync and dataen, one frame per trigger
    set_train(REG_HS_DLY2, 24'h3, 16'h2, 16'h3, 16'h3);
    set_train(REG_DE_DLY2, 24'h5, 16'h4, 16'h2, 16'h2);
    wr(REG_CTRL, 8'h07);
    run_frame(2);
    chk("hs_pulses", 3, i_vtpg_pipe_sink.hs_pulses);
    chk("hsync_high_time", 6, i_vtpg_pipe_sink.hs_highs);
    chk("hs_span", 12, i_vtpg_pipe_sink.hs_last - i_vtpg_pipe_sink.hs_first);
    chk("de_pulses", 2, i_vtpg_pipe_sink.de_pulses);
    chk("dataen_high_time", 8, i_vtpg_pipe_sink.de_highs);
    chk("de_span", 10, i_vtpg_pipe_sink.de_last - i_vtpg_pipe_sink.de_first);
    chk("de_vs_hs", 2, i_vtpg_pipe_sink.de_first - i_vtpg_pipe_sink.hs_first);
    // short trains with no delay in tracking, one-trigger and auto-repeat modes
    set_train(REG_HS_DLY2, 24'h0, 16'h2, 16'h2, 16'h2);
    set_train(REG_DE_DLY2, 24'h0, 16'h1, 16'h1, 16'h1);
    for (int m = 0; m < 3; m++) begin
      wr(REG_CTRL, {4'h0, 2'(m), 2'b11});
      run_frame(1);
      chk("short_hs", 2, i_vtpg_pipe_sink.hs_pulses);
      chk("short_hsync_high_time", 4, i_vtpg_pipe_sink.hs_highs);
      chk("short_de", 1, i_vtpg_pipe_sink.de_pulses);
      chk("short_dataen_high_time", 1, i_vtpg_pipe_sink.de_highs);
    end
    // checkerboard: runs of 2 and 3, phase swap every line
    set_train(REG_HS_DLY2, 24'h0, 16'h0, 16'h0, 16'h0);
    set_train(REG_DE_DLY2, 24'h2, 16'h8, 16'h4, 16'h3);
    wr(REG_A_RED, 8'h11);
    wr(REG_A_GRN, 8'h22);
    wr(REG_A_BLU, 8'h33);
    wr(REG_B_RED, 8'haa);
    wr(REG_B_GRN, 8'hbb);
    wr(REG_B_BLU, 8'hcc);
    wr(REG_A_RUN, 8'h02);
    wr(REG_B_RUN, 8'h03);
    wr(REG_CHK_ALT, 8'h01);
    wr(REG_PAT_MODE, 8'h01);
    wr(REG_CTRL, 8'h06);
    run_frame(3);
    chk("chk_count", 24, i_vtpg_pipe_sink.pix_q.size());
    for (int k = 0; k < 8; k++) begin
      chk("chk_line0", (k % 5 < 2) ? 32'h112233 : 32'haabbcc, {8'h0, i_vtpg_pipe_sink.pix_q[k]});
    end
    chk("chk_line1", 32'haabbcc, {8'h0, i_vtpg_pipe_sink.pix_q[8]});
    chk("chk_line2", 32'h112233, {8'h0, i_vtpg_pipe_sink.pix_q[16]});
    // square cells: both runs and the line alternation equal
    wr(REG_B_RUN, 8'h02);
    wr(REG_CHK_ALT, 8'h02);
    run_frame(3);
    chk("sq_line1", 32'h112233, {8'h0, i_vtpg_pipe_sink.pix_q[8]});
    chk("sq_line2", 32'haabbcc, {8'h0, i_vtpg_pipe_sink.pix_q[16]});
    // gradient: default step up, wide step up and down with wrap
    set_train(REG_DE_DLY2, 24'h2, 16'ha, 16'h4, 16'h2);
    for (int c = 0; c < 3; c++) begin
      inc = (c == 0) ? 8'h04 : 8'h80;
      dir = (c == 2);
      wr(REG_PAT_MODE, {5'h0, dir, 2'b10});
      wr(REG_GRADIENT_STEP_X4, inc);
      run_frame(2);
      for (int k = 0; k < 10; k++) begin
        v = 8'((k * (inc / 4)) % 256);
        v = dir ? 8'hff - v : v;
        chk("grad_pix", {8'h0, v, v, v}, {8'h0, i_vtpg_pipe_sink.pix_q[k]});
      end
      v = dir ? 8'hff : 8'h00;
      chk("grad_line1", {8'h0, v, v, v}, {8'h0, i_vtpg_pipe_sink.pix_q[10]});
    end
    wrap_up();
  end
endmodule
